// ---- apl_pkg.sv ----
package apl_pkg;

    // ==========================================================
    // register offsets on the serial port
    localparam logic [14:0] ADDR_POWER_TUNE_ONE   = 15'h0037;
    localparam logic [14:0] ADDR_SOFT_TRIGGER     = 15'h006C;
    localparam logic [14:0] ADDR_POWER_TUNE_TWO   = 15'h029A;
    localparam logic [14:0] ADDR_POWER_TUNE_THREE = 15'h029B;
    localparam logic [14:0] ADDR_POWER_TUNE_FOUR  = 15'h029C;
    localparam logic [14:0] ADDR_CAL_ENABLE       = 15'h0061;
    localparam logic [14:0] ADDR_CAL_MODE         = 15'h0062;
    localparam logic [14:0] ADDR_TRIG_SELECT      = 15'h0063;
    localparam logic [14:0] ADDR_LINK_ENABLE      = 15'h0200;
    localparam logic [14:0] ADDR_LINK_MODE        = 15'h0201;
    localparam logic [14:0] ADDR_FRAMES_M1        = 15'h0202;

    // ==========================================================
    // values after reset: high-performance mode
    localparam logic [7:0] RST_POWER_TUNE_ONE   = 8'h4B;
    localparam logic [7:0] RST_POWER_TUNE_TWO   = 8'h0F;
    localparam logic [7:0] RST_POWER_TUNE_THREE = 8'h04;
    localparam logic [7:0] RST_POWER_TUNE_FOUR  = 8'h1B;
    localparam logic [4:0] RST_LINK_MODE        = 5'h00;
    localparam logic [4:0] RST_FRAMES_M1        = 5'h1F;

    // low-power values the host writes
    localparam logic [7:0] LP_POWER_TUNE_ONE   = 8'h46;
    localparam logic [7:0] LP_POWER_TUNE_TWO   = 8'h06;
    localparam logic [7:0] LP_POWER_TUNE_THREE = 8'h00;
    localparam logic [7:0] LP_POWER_TUNE_FOUR  = 8'h14;

    // tuning-three value whose glitch matches high-performance mode
    localparam logic [7:0] GLITCH_MATCH_HP = 8'h04;

    // ==========================================================
    // serial frame layout: read flag, 15 address bits, 8 data bits
    localparam logic [4:0] SPI_HDR_LAST_BIT   = 5'h0F;
    localparam logic [4:0] SPI_FRAME_LAST_BIT = 5'h17;
    localparam logic [4:0] SPI_FRAME_BITS     = 5'h18;

    // ==========================================================
    // handover timing, in sample clocks
    localparam int HANDOVER_DELAY_MIN_CLK = 500;
    localparam int HANDOVER_DELAY_MAX_CLK = 1000;
    localparam int HANDOVER_DELAY_CLK     = (HANDOVER_DELAY_MIN_CLK + HANDOVER_DELAY_MAX_CLK) / 2;
    localparam int HANDOVER_PERIOD_CLK    = 2048;

    // ==========================================================
    // calibration modes
    typedef enum logic [1:0] {
        APL_CAL_FOREGROUND = 2'h0,
        APL_CAL_BACKGROUND = 2'h1,
        APL_CAL_LP_BACKGND = 2'h3
    } apl_cal_mode_e;

    // handover timer states
    typedef enum logic [1:0] {
        APL_HO_OFF   = 2'h0,
        APL_HO_ARMED = 2'h1,
        APL_HO_DELAY = 2'h3
    } apl_ho_state_e;

    // ==========================================================
    // link modes: low half 8B/10B, high half 64B/66B
    localparam logic [4:0] LINK_MODE_FIRST_64B66B = 5'h04;
    localparam logic [4:0] LINK_MODE_LAST         = 5'h07;
    localparam logic [7:0] LINK_R_TABLE [8] = '{
        8'h14, 8'h0A, 8'h05, 8'h28, 8'h11, 8'h08, 8'h04, 8'h21
    };
    localparam logic [5:0] LINK_E_64B66B = 6'h01;

endpackage : apl_pkg

// ---- apl_cal_if.sv ----
`timescale 1ns/1ps
interface apl_cal_if;
    logic       cal_enable;
    logic [1:0] cal_mode;
    logic       trig_select;
    logic       trigger;
    logic       handover;

    modport ctrl  (output cal_enable, output cal_mode, output trig_select,
                   output trigger, input handover);
    modport timer (input cal_enable, input cal_mode, input trig_select,
                   input trigger, output handover);
endinterface : apl_cal_if

// ---- apl_handover_timer.sv ----
`timescale 1ns/1ps
module apl_handover_timer #(
    parameter int DELAY_CLK  = apl_pkg::HANDOVER_DELAY_CLK,
    parameter int PERIOD_CLK = apl_pkg::HANDOVER_PERIOD_CLK
) (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_reset_n,
    // calibration controls
    apl_cal_if.timer  cal
);
    localparam int          CW        = 12;
    localparam logic [CW-1:0] DELAY_LAST  = CW'(DELAY_CLK - 1);
    localparam logic [CW-1:0] PERIOD_LAST = CW'(PERIOD_CLK - 1);

    apl_pkg::apl_ho_state_e state_q;
    logic [CW-1:0]          cnt_q;
    logic                   handover_q;
    logic                   active;

    // foreground calibration never swaps cores
    assign active = cal.cal_enable &&
                    (cal.cal_mode != apl_pkg::APL_CAL_FOREGROUND);
    assign cal.handover = handover_q;

    // ==========================================================
    // handover sequencing
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state_q    <= apl_pkg::APL_HO_OFF;
            cnt_q      <= '0;
            handover_q <= 1'b0;
        end else begin
            handover_q <= 1'b0;
            if (!active) begin
                state_q <= apl_pkg::APL_HO_OFF;
                cnt_q   <= '0;
            end else begin
                unique case (state_q)
                    apl_pkg::APL_HO_OFF: begin
                        state_q <= apl_pkg::APL_HO_ARMED;
                        cnt_q   <= '0;
                    end
                    apl_pkg::APL_HO_ARMED: begin
                        if (cal.cal_mode == apl_pkg::APL_CAL_LP_BACKGND && cal.trig_select) begin
                            // wait for a trigger, own schedule suspended
                            cnt_q <= '0;
                            if (cal.trigger) begin
                                state_q <= apl_pkg::APL_HO_DELAY;
                            end
                        end else if (cnt_q == PERIOD_LAST) begin
                            cnt_q      <= '0;
                            handover_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    apl_pkg::APL_HO_DELAY: begin
                        // later triggers during the delay are absorbed
                        if (cnt_q == DELAY_LAST) begin
                            cnt_q      <= '0;
                            handover_q <= 1'b1;
                            state_q    <= apl_pkg::APL_HO_ARMED;
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    default: begin
                        state_q <= apl_pkg::APL_HO_OFF;
                    end
                endcase
            end
        end
    end
endmodule : apl_handover_timer

// ---- apl_link_derive.sv ----
`timescale 1ns/1ps
module apl_link_derive (
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_reset_n,
    // host selections
    input  wire logic       i_link_enable,
    input  wire logic [4:0] i_link_mode,
    input  wire logic [4:0] i_frames_m1,
    // derived transport parameters
    output logic            o_link_reset,
    output logic            o_serializer_power_down,
    output logic            o_link_clock_enable,
    output logic            o_enc_64b66b,
    output logic            o_ilas_enable,
    output logic [7:0]      o_pll_multiplier,
    output logic [5:0]      o_frames_per_multiframe,
    output logic [5:0]      o_multiblocks_per_ext
);
    logic       is_64;
    logic [2:0] idx;

    // modes above the table fold onto its last entry
    assign idx   = (i_link_mode > apl_pkg::LINK_MODE_LAST) ? 3'h7 : i_link_mode[2:0];
    assign is_64 = (i_link_mode >= apl_pkg::LINK_MODE_FIRST_64B66B);

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_link_reset            <= 1'b1;
            o_serializer_power_down <= 1'b1;
            o_link_clock_enable     <= 1'b0;
            o_enc_64b66b            <= 1'b0;
            o_ilas_enable           <= 1'b0;
            o_pll_multiplier        <= 8'h00;
            o_frames_per_multiframe <= 6'h00;
            o_multiblocks_per_ext   <= 6'h00;
        end else begin
            o_link_reset            <= !i_link_enable;
            o_serializer_power_down <= !i_link_enable;
            o_link_clock_enable     <= i_link_enable;
            o_enc_64b66b            <= is_64;
            // line rate is fs times this factor
            o_pll_multiplier        <= apl_pkg::LINK_R_TABLE[idx];
            o_ilas_enable           <= i_link_enable && !is_64;
            o_frames_per_multiframe <= is_64 ? 6'h00 : ({1'b0, i_frames_m1} + 6'h01);
            o_multiblocks_per_ext   <= is_64 ? apl_pkg::LINK_E_64B66B : 6'h00;
        end
    end
endmodule : apl_link_derive

// ---- apl_mode_config.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - register defaults after reset give high-performance mode with no programming.
// - tuning register three trades power against core-handover glitch size.
// - tuning register three at four gives the high-performance glitch size.
// - low-power background with triggered handover set waits for a trigger.
// - handover appears 500 to 1000 sample clocks after pin or software trigger.
// - foreground calibration performs no core handovers.
// - all hidden transport parameters derive from the link mode selection.
// - per-lane line rate is sampling rate times bits per lane R.
// - R drives the serializer PLL multiplication factor.
// - E is fixed at one in 64B/66B and ignored in 8B/10B.
// - 8B/10B modes send all transport parameters in lane alignment sequence.
// - 64B/66B modes send no alignment sequence, same transport parameters.
// - link enable low holds link in reset, serializers down, clocks gated.
module apl_mode_config (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_reset_n,
    // serial register port
    input  wire logic i_spi_sclk,
    input  wire logic i_spi_cs_n,
    input  wire logic i_spi_sdi,
    output logic      o_spi_sdo,
    output logic      o_spi_sdo_oe_n,
    // calibration trigger pin
    input  wire logic i_cal_trigger_pin,
    // power tuning to the converter cores
    output logic [7:0] o_power_tune_one,
    output logic [7:0] o_power_tune_two,
    output logic [7:0] o_power_tune_three,
    output logic [7:0] o_power_tune_four,
    output logic       o_glitch_matches_hp,
    // calibration
    output logic       o_cal_enable,
    output logic [1:0] o_cal_mode,
    output logic       o_core_handover,
    // serial link
    output logic       o_link_reset,
    output logic       o_serializer_power_down,
    output logic       o_link_clock_enable,
    output logic       o_enc_64b66b,
    output logic       o_ilas_enable,
    output logic [7:0] o_pll_multiplier,
    output logic [5:0] o_frames_per_multiframe,
    output logic [5:0] o_multiblocks_per_ext
);
    // ==========================================================
    // pin synchronisers
    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic csn_s1_q, csn_s2_q;
    logic sdi_s1_q, sdi_s2_q;
    logic trg_s1_q, trg_s2_q, trg_s3_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            csn_s1_q  <= 1'b1;
            csn_s2_q  <= 1'b1;
            sdi_s1_q  <= 1'b0;
            sdi_s2_q  <= 1'b0;
            trg_s1_q  <= 1'b0;
            trg_s2_q  <= 1'b0;
            trg_s3_q  <= 1'b0;
        end else begin
            sclk_s1_q <= i_spi_sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            csn_s1_q  <= i_spi_cs_n;
            csn_s2_q  <= csn_s1_q;
            sdi_s1_q  <= i_spi_sdi;
            sdi_s2_q  <= sdi_s1_q;
            trg_s1_q  <= i_cal_trigger_pin;
            trg_s2_q  <= trg_s1_q;
            trg_s3_q  <= trg_s2_q;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = sclk_s2_q && !sclk_s3_q;
    assign sclk_fall = !sclk_s2_q && sclk_s3_q;

    // ==========================================================
    // serial frame receiver
    logic [22:0] shift_q;
    logic [4:0]  bit_cnt_q;
    logic        rd_q;
    logic [14:0] addr_q;
    logic        rd_load_q;
    logic        wr_q;
    logic [7:0]  wr_data_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            shift_q   <= '0;
            bit_cnt_q <= 5'h00;
        end else if (csn_s2_q) begin
            bit_cnt_q <= 5'h00;
        end else if (sclk_rise && bit_cnt_q != apl_pkg::SPI_FRAME_BITS) begin
            // extra clocks past one frame are ignored
            shift_q   <= {shift_q[21:0], sdi_s2_q};
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            rd_q      <= 1'b0;
            addr_q    <= '0;
            rd_load_q <= 1'b0;
        end else begin
            rd_load_q <= 1'b0;
            if (!csn_s2_q && sclk_rise && bit_cnt_q == apl_pkg::SPI_HDR_LAST_BIT) begin
                rd_q      <= shift_q[14];
                addr_q    <= {shift_q[13:0], sdi_s2_q};
                rd_load_q <= shift_q[14];
            end
        end
    end

    // a write commits only on the last bit of a full frame
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            wr_q      <= 1'b0;
            wr_data_q <= 8'h00;
        end else begin
            wr_q <= !csn_s2_q && sclk_rise && !rd_q &&
                    bit_cnt_q == apl_pkg::SPI_FRAME_LAST_BIT;
            if (sclk_rise) begin
                wr_data_q <= {shift_q[6:0], sdi_s2_q};
            end
        end
    end

    // ==========================================================
    // register file
    logic [7:0] tune_one_q, tune_two_q, tune_three_q, tune_four_q;
    logic       cal_en_q;
    logic [1:0] cal_mode_q;
    logic       trig_sel_q;
    logic       link_en_q;
    logic [4:0] link_mode_q;
    logic [4:0] frames_m1_q;
    logic       soft_trig_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            tune_one_q   <= apl_pkg::RST_POWER_TUNE_ONE;
            tune_two_q   <= apl_pkg::RST_POWER_TUNE_TWO;
            tune_three_q <= apl_pkg::RST_POWER_TUNE_THREE;
            tune_four_q  <= apl_pkg::RST_POWER_TUNE_FOUR;
        end else if (wr_q) begin
            unique case (addr_q)
                apl_pkg::ADDR_POWER_TUNE_ONE:   tune_one_q   <= wr_data_q;
                apl_pkg::ADDR_POWER_TUNE_TWO:   tune_two_q   <= wr_data_q;
                apl_pkg::ADDR_POWER_TUNE_THREE: tune_three_q <= wr_data_q;
                apl_pkg::ADDR_POWER_TUNE_FOUR:  tune_four_q  <= wr_data_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            cal_en_q    <= 1'b0;
            cal_mode_q  <= apl_pkg::APL_CAL_FOREGROUND;
            trig_sel_q  <= 1'b0;
            link_en_q   <= 1'b0;
            link_mode_q <= apl_pkg::RST_LINK_MODE;
            frames_m1_q <= apl_pkg::RST_FRAMES_M1;
        end else if (wr_q) begin
            unique case (addr_q)
                apl_pkg::ADDR_CAL_ENABLE:  cal_en_q    <= wr_data_q[0];
                apl_pkg::ADDR_CAL_MODE:    cal_mode_q  <= wr_data_q[1:0];
                apl_pkg::ADDR_TRIG_SELECT: trig_sel_q  <= wr_data_q[0];
                apl_pkg::ADDR_LINK_ENABLE: link_en_q   <= wr_data_q[0];
                apl_pkg::ADDR_LINK_MODE:   link_mode_q <= wr_data_q[4:0];
                apl_pkg::ADDR_FRAMES_M1:   frames_m1_q <= wr_data_q[4:0];
                default: ;
            endcase
        end
    end

    // software trigger stores nothing, it only fires
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            soft_trig_q <= 1'b0;
        end else begin
            soft_trig_q <= wr_q && addr_q == apl_pkg::ADDR_SOFT_TRIGGER;
        end
    end

    // ==========================================================
    // read back
    logic [7:0] rd_data;

    always_comb begin
        rd_data = 8'h00;
        unique case (addr_q)
            apl_pkg::ADDR_POWER_TUNE_ONE:   rd_data = tune_one_q;
            apl_pkg::ADDR_POWER_TUNE_TWO:   rd_data = tune_two_q;
            apl_pkg::ADDR_POWER_TUNE_THREE: rd_data = tune_three_q;
            apl_pkg::ADDR_POWER_TUNE_FOUR:  rd_data = tune_four_q;
            apl_pkg::ADDR_CAL_ENABLE:       rd_data = {7'h00, cal_en_q};
            apl_pkg::ADDR_CAL_MODE:         rd_data = {6'h00, cal_mode_q};
            apl_pkg::ADDR_TRIG_SELECT:      rd_data = {7'h00, trig_sel_q};
            apl_pkg::ADDR_LINK_ENABLE:      rd_data = {7'h00, link_en_q};
            apl_pkg::ADDR_LINK_MODE:        rd_data = {3'h0, link_mode_q};
            apl_pkg::ADDR_FRAMES_M1:        rd_data = {3'h0, frames_m1_q};
            apl_pkg::ADDR_SOFT_TRIGGER:     rd_data = 8'h00;
            default:                        rd_data = 8'h00;
        endcase
    end

    // data changes on falling sclk so the host samples it on rising
    logic [7:0] sdo_shift_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            sdo_shift_q    <= 8'h00;
            o_spi_sdo      <= 1'b0;
            o_spi_sdo_oe_n <= 1'b1;
        end else begin
            if (rd_load_q) begin
                sdo_shift_q <= rd_data;
                o_spi_sdo   <= rd_data[7];
            end else if (sclk_fall && bit_cnt_q > apl_pkg::SPI_HDR_LAST_BIT + 5'h01) begin
                sdo_shift_q <= {sdo_shift_q[6:0], 1'b0};
                o_spi_sdo   <= sdo_shift_q[6];
            end
            o_spi_sdo_oe_n <= !(!csn_s2_q && rd_q && bit_cnt_q > apl_pkg::SPI_HDR_LAST_BIT);
        end
    end

    // ==========================================================
    // calibration trigger and handover timing
    apl_cal_if cal_bus ();

    assign cal_bus.cal_enable  = cal_en_q;
    assign cal_bus.cal_mode    = cal_mode_q;
    assign cal_bus.trig_select = trig_sel_q;
    assign cal_bus.trigger     = (trg_s2_q && !trg_s3_q) || soft_trig_q;

    apl_handover_timer u_timer (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .cal        (cal_bus.timer)
    );

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_core_handover     <= 1'b0;
            o_glitch_matches_hp <= 1'b1;
        end else begin
            o_core_handover     <= cal_bus.handover;
            o_glitch_matches_hp <= tune_three_q >= apl_pkg::GLITCH_MATCH_HP;
        end
    end

    assign o_power_tune_one   = tune_one_q;
    assign o_power_tune_two   = tune_two_q;
    assign o_power_tune_three = tune_three_q;
    assign o_power_tune_four  = tune_four_q;
    assign o_cal_enable       = cal_en_q;
    assign o_cal_mode         = cal_mode_q;

    // ==========================================================
    // serial link parameters
    apl_link_derive u_link (
        .i_core_clk              (i_core_clk),
        .i_reset_n               (i_reset_n),
        .i_link_enable           (link_en_q),
        .i_link_mode             (link_mode_q),
        .i_frames_m1             (frames_m1_q),
        .o_link_reset            (o_link_reset),
        .o_serializer_power_down (o_serializer_power_down),
        .o_link_clock_enable     (o_link_clock_enable),
        .o_enc_64b66b            (o_enc_64b66b),
        .o_ilas_enable           (o_ilas_enable),
        .o_pll_multiplier        (o_pll_multiplier),
        .o_frames_per_multiframe (o_frames_per_multiframe),
        .o_multiblocks_per_ext   (o_multiblocks_per_ext)
    );
endmodule : apl_mode_config

// ---- apl_mode_config_asserts.sv ----
`timescale 1ns/1ps
module apl_mode_config_asserts (
    // clock and reset
    input wire logic       i_core_clk,
    input wire logic       i_reset_n,
    // serial select
    input wire logic       i_spi_cs_n,
    input wire logic       o_spi_sdo_oe_n,
    // watched outputs
    input wire logic [7:0] o_power_tune_three,
    input wire logic       o_glitch_matches_hp,
    input wire logic       o_cal_enable,
    input wire logic [1:0] o_cal_mode,
    input wire logic       o_core_handover,
    input wire logic       o_link_reset,
    input wire logic       o_serializer_power_down,
    input wire logic       o_link_clock_enable,
    input wire logic       o_enc_64b66b,
    input wire logic       o_ilas_enable,
    input wire logic [5:0] o_frames_per_multiframe,
    input wire logic [5:0] o_multiblocks_per_ext
);
    // ==========================================
    // link and calibration relations
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_pulse; o_core_handover ##1 !o_core_handover; endsequence
    a_link_held_off: assert property (
        !o_link_clock_enable |-> o_link_reset && o_serializer_power_down)
        else $error("link not held off");
    a_ilas_by_mode: assert property (
        o_ilas_enable == (o_link_clock_enable && !o_enc_64b66b))
        else $error("ilas enable wrong");
    a_ext_one_64: assert property (o_enc_64b66b |-> o_multiblocks_per_ext == 6'h01)
        else $error("E not one");
    a_ext_zero_8b: assert property (!o_enc_64b66b |-> o_multiblocks_per_ext == 6'h00)
        else $error("E not ignored");
    a_k_ignored_64: assert property (o_enc_64b66b |-> o_frames_per_multiframe == 6'h00)
        else $error("K not ignored");
    a_glitch_tracks: assert property (
        1'b1 |=> o_glitch_matches_hp == ($past(o_power_tune_three) >= 8'h04))
        else $error("glitch flag wrong");
    a_handover_pulse: assert property (o_core_handover |-> s_pulse)
        else $error("handover not one cycle");
    a_no_fg_handover: assert property (
        o_core_handover |-> o_cal_enable && o_cal_mode != 2'h0)
        else $error("handover outside background");
    // select seen high through the sync stages leaves the data pin released
    a_sdo_released: assert property (i_spi_cs_n [*3] |=> o_spi_sdo_oe_n)
        else $error("sdo driven while deselected");
endmodule : apl_mode_config_asserts

// ---- apl_spi_host.sv ----
`timescale 1ns/1ps
module apl_spi_host (
    // pacing clock
    input  wire logic i_core_clk,
    // serial port
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sdi,
    input  wire logic i_sdo
);
    // ==========================================
    // frame: read flag, address, data; halves of 5 cycles clear the 4-cycle floor
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b1;
    end
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [23:0] f;
        f = {rd, a, d};
        q = 8'h00;
        @(posedge i_core_clk) #1 o_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            o_sdi = f[i];
            repeat (5) @(posedge i_core_clk);
            #1 q = {q[6:0], i_sdo};
            o_sclk = 1'b1;
            repeat (5) @(posedge i_core_clk);
            #1 o_sclk = 1'b0;
        end
        repeat (5) @(posedge i_core_clk);
        #1 o_cs_n = 1'b1;
        // released data line must not keep its last bit
        o_sdi = ~o_sdi;
        repeat (4) @(posedge i_core_clk);
    endtask : xfer
endmodule : apl_spi_host

// ---- tb_apl_mode_config.sv ----
`timescale 1ns/1ps
module tb_apl_mode_config;
    logic i_core_clk, i_reset_n, i_spi_sclk, i_spi_cs_n, i_spi_sdi, i_cal_trigger_pin;
    logic o_spi_sdo, o_spi_sdo_oe_n, o_glitch_matches_hp, o_cal_enable, o_core_handover;
    logic o_link_reset, o_serializer_power_down, o_link_clock_enable, o_enc_64b66b;
    logic o_ilas_enable;
    logic [1:0] o_cal_mode;
    logic [5:0] o_frames_per_multiframe, o_multiblocks_per_ext;
    logic [7:0] o_power_tune_one, o_power_tune_two, o_power_tune_three, o_power_tune_four;
    logic [7:0] o_pll_multiplier, q;
    logic [14:0] ta [4] = '{15'h037, 15'h29A, 15'h29B, 15'h29C};
    logic [7:0] lp [4] = '{8'h46, 8'h06, 8'h00, 8'h14};
    logic [7:0] hp [4] = '{8'h4B, 8'h0F, 8'h04, 8'h1B};
    int failures, checks_done, cycles, n, k;
    int mdl [int];
    apl_mode_config dut_u (.*);
    apl_spi_host host_u (.i_core_clk(i_core_clk), .o_sclk(i_spi_sclk), .o_cs_n(i_spi_cs_n),
                         .o_sdi(i_spi_sdi), .i_sdo(o_spi_sdo));
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    // run needs about 25k cycles
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host_u.xfer(1'b0, a, d, q);
        if (mdl.exists(int'(a))) mdl[int'(a)] = int'(d);
    endtask : wr
    task automatic rd(input logic [14:0] a);
        host_u.xfer(1'b1, a, 8'h00, q);
        chk(q, mdl.exists(int'(a)) ? 8'(mdl[int'(a)]) : 8'h00);
    endtask : rd
    task automatic tune_chk();
        chk(o_power_tune_one, 8'(mdl['h037]));
        chk(o_power_tune_two, 8'(mdl['h29A]));
        chk(o_power_tune_three, 8'(mdl['h29B]));
        chk(o_power_tune_four, 8'(mdl['h29C]));
        chk({7'h00, o_glitch_matches_hp}, {7'h00, mdl['h29B] >= 4});
    endtask : tune_chk
    task automatic ho_wait(input int lo);
        n = 0;
        while (o_core_handover !== 1'b1 && n < 1100) begin
            @(posedge i_core_clk);
            #1 n++;
        end
        chk({7'h00, n >= lo && n <= 1000}, 8'h01);
    endtask : ho_wait
    task automatic quiet(input int e);
        n = 0;
        repeat (2100) begin
            @(posedge i_core_clk);
            #1 n += int'(o_core_handover === 1'b1);
        end
        chk(8'(n), 8'(e));
    endtask : quiet
    // ==========================================
    // main sequence
    initial begin
        i_reset_n = 1'b0;
        i_cal_trigger_pin = 1'b0;
        mdl = '{'h037: 'h4B, 'h29A: 'h0F, 'h29B: 'h04, 'h29C: 'h1B, 'h061: 'h00,
                'h062: 'h00, 'h063: 'h00, 'h200: 'h00, 'h201: 'h00, 'h202: 'h1F};
        void'($urandom(32'hF944));
        repeat (20) @(posedge i_core_clk);
        #1 i_reset_n = 1'b1;
        foreach (ta[r]) rd(ta[r]);
        rd(15'h06C);
        rd(15'h123);
        rd(15'h202);
        tune_chk();
        for (int m = 0; m < 3; m++) begin
            // sample rate assumed below one gigasample, input in the first zone
            for (int r = 0; r < 4; r++) begin
                wr(ta[r], m == 2 ? 8'($urandom) : m ? hp[r] : lp[r]);
            end
            foreach (ta[r]) rd(ta[r]);
            tune_chk();
        end
        chk({7'h00, o_link_reset & o_serializer_power_down}, 8'h01);
        for (int m = 0; m < 8; m++) begin
            k = $urandom % 32;
            wr(15'h200, 8'h00);
            wr(15'h201, 8'(m));
            wr(15'h202, 8'(k));
            wr(15'h200, 8'h01);
            chk(o_pll_multiplier, apl_pkg::LINK_R_TABLE[m]);
            chk(8'({o_ilas_enable, o_link_clock_enable}), {6'h00, m < 4, 1'b1});
            chk({2'h0, o_frames_per_multiframe}, m < 4 ? 8'(k + 1) : 8'h00);
            chk({2'h0, o_multiblocks_per_ext}, {7'h00, m >= 4});
        end
        wr(15'h200, 8'h00);
        wr(15'h062, 8'h03);
        wr(15'h063, 8'h01);
        wr(15'h061, 8'h01);
        chk({5'h00, o_cal_enable, o_cal_mode}, {5'h00, 1'b1, 2'h3});
        rd(15'h063);
        quiet(0);
        wr(15'h06C, 8'($urandom));
        ho_wait(480);
        @(posedge i_core_clk) #1 i_cal_trigger_pin = 1'b1;
        ho_wait(500);
        i_cal_trigger_pin = 1'b0;
        wr(15'h062, 8'h01);
        quiet(1);
        wr(15'h062, 8'h00);
        rd(15'h062);
        wr(15'h06C, 8'h01);
        quiet(0);
        test_done();
    end
endmodule : tb_apl_mode_config
bind apl_mode_config apl_mode_config_asserts chk_u (.*);
